// [shared/pcseq_regs.svh]
// Register offsets, reset values and field positions of the fetch address unit
`ifndef PCSEQ_REGS_SVH
`define PCSEQ_REGS_SVH

`define PCSEQ_ADDR_LOW       8'h02
`define PCSEQ_ADDR_LATCH     8'h03
`define PCSEQ_ADDR_CTRL      8'h04
`define PCSEQ_ADDR_STAT      8'h05
`define PCSEQ_PC_RESET       16'h0000
`define PCSEQ_LATCH_RESET    8'h00
`define PCSEQ_VECTOR_RESET   16'h0020
`define PCSEQ_PAGE_LSB       13
`define PCSEQ_CTRL_GID_BIT   0
`define PCSEQ_PHASES         4
`define PCSEQ_PHASE_FIRST    2'h0
`define PCSEQ_PHASE_LAST     2'h3

`endif

// [shared/pcseq_pkg.sv]
// Types shared by the fetch address unit
package pcseq_pkg;

	typedef enum logic [2:0] {
		PCSEQ_OP_NONE,
		PCSEQ_OP_BRANCH,
		PCSEQ_OP_LONG_CALL,
		PCSEQ_OP_RETURN,
		PCSEQ_OP_RET_LIT,
		PCSEQ_OP_RET_INT,
		PCSEQ_OP_SKIP
	} pcseq_op_e;

	typedef struct packed {
		pcseq_op_e   op;
		logic [15:0] opcode;
		logic [15:0] stack_top;
	} pcseq_cmd_s;

	typedef struct packed {
		logic [15:0] addr;
		logic        forced_nop;
	} pcseq_fetch_s;

endpackage

// [rtl/pcseq_core.sv]
// Program counter, high-byte holding latch and their data-memory port
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "pcseq_regs.svh"

module pcseq_core #(
	parameter logic [15:0] VECTOR = `PCSEQ_VECTOR_RESET
) (
	input  wire logic                  mclk_i,
	input  wire logic                  resetn_i,
	input  wire logic [7:0]            reg_addr_i,
	input  wire logic [7:0]            reg_wdata_i,
	input  wire logic                  reg_write_i,
	input  wire logic                  reg_read_i,
	input  wire logic                  reg_rmw_i,
	output logic      [7:0]            reg_rdata_o,
	input  wire logic                  cmd_valid_i,
	input  wire pcseq_pkg::pcseq_cmd_s cmd_i,
	input  wire logic                  wake_irq_i,
	output pcseq_pkg::pcseq_fetch_s    fetch_o,
	output logic                       fetch_strobe_o,
	output logic      [1:0]            phase_o
);

	logic [15:0] pc_q;
	logic [7:0]  latch_q;
	logic [1:0]  phase_q;
	logic        skip_q;
	logic        gid_q;
	logic [7:0]  rdata_q;
	logic        wake_q1;
	logic        wake_q2;
	logic        wake_d;
	logic        vector_go;
	logic        q1;
	logic        low_wr;
	logic        low_rd;
	logic        latch_wr;

	assign q1        = (phase_q == `PCSEQ_PHASE_FIRST);
	assign low_wr    = reg_write_i && (reg_addr_i == `PCSEQ_ADDR_LOW);
	assign low_rd    = reg_read_i && (reg_addr_i == `PCSEQ_ADDR_LOW);
	assign latch_wr  = reg_write_i && (reg_addr_i == `PCSEQ_ADDR_LATCH);
	assign vector_go = wake_q2 && !wake_d && !gid_q;

	// Quarter phase counter
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase_q <= `PCSEQ_PHASE_FIRST;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// Wake request synchroniser and edge
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wake_q1 <= 1'b0;
			wake_q2 <= 1'b0;
			wake_d  <= 1'b0;
		end else begin
			wake_q1 <= wake_irq_i;
			wake_q2 <= wake_q1;
			wake_d  <= wake_q2;
		end
	end

	// Global interrupt disable control bit
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			gid_q <= 1'b0;
		end else if (reg_write_i && reg_addr_i == `PCSEQ_ADDR_CTRL) begin
			gid_q <= reg_wdata_i[`PCSEQ_CTRL_GID_BIT];
		end
	end

	// Fetch address
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pc_q <= `PCSEQ_PC_RESET;
		end else if (vector_go) begin
			pc_q <= VECTOR;
		end else if (low_wr) begin
			pc_q <= {latch_q, reg_wdata_i};
		end else if (cmd_valid_i) begin
			case (cmd_i.op)
				pcseq_pkg::PCSEQ_OP_BRANCH: begin
					pc_q <= {pc_q[15:`PCSEQ_PAGE_LSB], cmd_i.opcode[12:0]};
				end
				pcseq_pkg::PCSEQ_OP_LONG_CALL: begin
					pc_q <= {latch_q, cmd_i.opcode[7:0]};
				end
				pcseq_pkg::PCSEQ_OP_RETURN,
				pcseq_pkg::PCSEQ_OP_RET_LIT,
				pcseq_pkg::PCSEQ_OP_RET_INT: begin
					pc_q <= cmd_i.stack_top;
				end
				default: begin
					if (q1) begin
						pc_q <= pc_q + 16'h0001;
					end
				end
			endcase
		end else if (q1) begin
			pc_q <= pc_q + 16'h0001;
		end
	end

	// Holding latch
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			latch_q <= `PCSEQ_LATCH_RESET;
		end else if (latch_wr) begin
			latch_q <= reg_wdata_i;
		end else if (low_rd && !reg_rmw_i) begin
			latch_q <= pc_q[15:8];
		end else if (cmd_valid_i && !vector_go && !low_wr) begin
			case (cmd_i.op)
				pcseq_pkg::PCSEQ_OP_BRANCH: begin
					latch_q <= {pc_q[15:`PCSEQ_PAGE_LSB], cmd_i.opcode[12:8]};
				end
				pcseq_pkg::PCSEQ_OP_RETURN: begin
					latch_q <= cmd_i.stack_top[15:8];
				end
				default: begin
					latch_q <= latch_q;
				end
			endcase
		end
	end

	// Skip marks the next fetch as a forced no-op
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			skip_q <= 1'b0;
		end else if (cmd_valid_i && cmd_i.op == pcseq_pkg::PCSEQ_OP_SKIP) begin
			skip_q <= 1'b1;
		end else if (q1) begin
			skip_q <= 1'b0;
		end
	end

	// Registered fetch output
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			fetch_o <= '0;
		end else if (q1) begin
			fetch_o.addr       <= pc_q;
			fetch_o.forced_nop <= skip_q;
		end
	end

	// Register read port
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_q <= 8'h00;
		end else if (reg_read_i) begin
			case (reg_addr_i)
				`PCSEQ_ADDR_LOW:   rdata_q <= pc_q[7:0];
				`PCSEQ_ADDR_LATCH: rdata_q <= latch_q;
				`PCSEQ_ADDR_CTRL:  rdata_q <= {7'h00, gid_q};
				`PCSEQ_ADDR_STAT:  rdata_q <= {6'h00, phase_q};
				default:           rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end

	assign reg_rdata_o    = rdata_q;
	assign fetch_strobe_o = (phase_q == `PCSEQ_PHASE_LAST);
	assign phase_o        = phase_q;

	// Checks of the fetch address rules
	a_q1_increment: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		resetn_i && q1 && !cmd_valid_i && !low_wr && !vector_go
		|=> pc_q == $past(pc_q) + 16'h0001)
		else $error("fetch address did not increment");

	a_no_increment: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!q1 && !cmd_valid_i && !low_wr && !vector_go
		|=> $stable(pc_q))
		else $error("fetch address moved outside first phase");

	a_phase_step: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		resetn_i
		|=> phase_q == $past(phase_q) + 2'h1)
		else $error("quarter phase did not advance");

	a_fetch_load: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		q1
		|=> fetch_o.addr == $past(pc_q))
		else $error("fetch output did not take address");

	a_fetch_holds: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!q1
		|=> $stable(fetch_o))
		else $error("fetch output changed outside first phase");

	a_low_write_page: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		low_wr && !vector_go
		|=> pc_q == {$past(latch_q), $past(reg_wdata_i)})
		else $error("low byte write did not take latch page");

	a_latch_write: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		latch_wr
		|=> latch_q == $past(reg_wdata_i))
		else $error("latch write lost");

	a_high_hidden: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		reg_write_i && !low_wr && !cmd_valid_i && !vector_go && !q1
		|=> $stable(pc_q))
		else $error("register write reached high byte");

	a_read_copies: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		low_rd && !reg_rmw_i && !latch_wr
		|=> latch_q == $past(pc_q[15:8]))
		else $error("low byte read did not copy high byte");

	a_read_low: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		low_rd
		|=> reg_rdata_o == $past(pc_q[7:0]))
		else $error("low byte read data wrong");

	a_rdata_idle: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		!reg_read_i
		|=> reg_rdata_o == 8'h00)
		else $error("read data outside read cycle");

	a_long_call: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		cmd_valid_i && cmd_i.op == pcseq_pkg::PCSEQ_OP_LONG_CALL
		&& !low_wr && !vector_go && !latch_wr && !low_rd
		|=> pc_q == {$past(latch_q), $past(cmd_i.opcode[7:0])} && $stable(latch_q))
		else $error("long call load wrong");

	a_return_load: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		cmd_valid_i && cmd_i.op == pcseq_pkg::PCSEQ_OP_RETURN
		&& !low_wr && !vector_go && !latch_wr && !low_rd
		|=> pc_q == $past(cmd_i.stack_top) && latch_q == $past(cmd_i.stack_top[15:8]))
		else $error("return load wrong");

	a_ret_lit_load: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		cmd_valid_i && cmd_i.op == pcseq_pkg::PCSEQ_OP_RET_LIT && !low_wr && !vector_go
		|=> pc_q == $past(cmd_i.stack_top))
		else $error("literal return load wrong");

	a_ret_lit_keeps: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		cmd_valid_i && cmd_i.op == pcseq_pkg::PCSEQ_OP_RET_LIT && !latch_wr && !low_rd
		|=> $stable(latch_q))
		else $error("literal return changed latch");

	a_ret_int_keeps: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		cmd_valid_i && cmd_i.op == pcseq_pkg::PCSEQ_OP_RET_INT
		&& !low_wr && !vector_go && !latch_wr && !low_rd
		|=> pc_q == $past(cmd_i.stack_top) && $stable(latch_q))
		else $error("interrupt return load wrong");

	a_branch_load: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		cmd_valid_i && cmd_i.op == pcseq_pkg::PCSEQ_OP_BRANCH
		&& !low_wr && !vector_go && !latch_wr && !low_rd
		|=> pc_q == {$past(pc_q[15:13]), $past(cmd_i.opcode[12:0])}
		&& latch_q == {$past(pc_q[15:13]), $past(cmd_i.opcode[12:8])})
		else $error("branch load wrong");

	a_vector_load: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		vector_go
		|=> pc_q == VECTOR)
		else $error("interrupt vector not loaded");

	a_vector_keeps: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		vector_go && !latch_wr && !low_rd && !cmd_valid_i
		|=> $stable(latch_q))
		else $error("vector load changed latch");

	a_skip_nop: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		cmd_valid_i && cmd_i.op == pcseq_pkg::PCSEQ_OP_SKIP
		|-> ##[1:5] fetch_o.forced_nop)
		else $error("skip did not force a no-op");

	a_rmw_keeps: assert property (@(posedge mclk_i) disable iff (!resetn_i)
		low_rd && reg_rmw_i && !latch_wr
		|=> $stable(latch_q))
		else $error("modify-write changed latch");

	c_branch: cover property (@(posedge mclk_i) cmd_valid_i && cmd_i.op == pcseq_pkg::PCSEQ_OP_BRANCH);
	c_call:   cover property (@(posedge mclk_i)
		cmd_valid_i && cmd_i.op == pcseq_pkg::PCSEQ_OP_LONG_CALL);
	c_jump:   cover property (@(posedge mclk_i) latch_wr ##[1:4] low_wr);
	c_vector: cover property (@(posedge mclk_i) vector_go);
	c_skip:   cover property (@(posedge mclk_i) fetch_o.forced_nop);

endmodule // pcseq_core

// [test/pcseq_partner.sv]
// Return stack model that feeds the most recent entry to the core
`timescale 1ns/1ps
module pcseq_partner (
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	input  wire logic        push_i,
	input  wire logic [15:0] push_data_i,
	output logic      [15:0] top_o
);
	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i)
			top_o <= 16'h0000;
		else if (push_i)
			top_o <= push_data_i;
	end
endmodule // pcseq_partner

// [test/program_counter_sequencer_tb.sv]
// Self-checking bench of the fetch address unit
`timescale 1ns/1ps
`include "pcseq_regs.svh"
module program_counter_sequencer_tb;
	typedef struct {
		pcseq_pkg::pcseq_op_e op;
		logic [15:0]          arg, ea;
		logic [7:0]           el;
	} pcseq_row_s;
	logic                    mclk_i, resetn_i, wr, rd, rmw, cv, wake, push, stb;
	logic [7:0]              addr, wdata, rdata, v;
	logic [15:0]             opc, pdata, top, f;
	logic [1:0]              ph;
	pcseq_pkg::pcseq_op_e    op;
	pcseq_pkg::pcseq_fetch_s fetch;
	int                      fails, num_checks, cyc;
	pcseq_row_s rows[6] = '{
		'{pcseq_pkg::PCSEQ_OP_NONE, 16'h1234, 16'h1234, 8'h12},
		'{pcseq_pkg::PCSEQ_OP_LONG_CALL, 16'h00ab, 16'h12ab, 8'h12},
		'{pcseq_pkg::PCSEQ_OP_BRANCH, 16'h1f05, 16'h1f05, 8'h1f},
		'{pcseq_pkg::PCSEQ_OP_RETURN, 16'hbeef, 16'hbeef, 8'hbe},
		'{pcseq_pkg::PCSEQ_OP_RET_LIT, 16'h4321, 16'h4321, 8'hbe},
		'{pcseq_pkg::PCSEQ_OP_RET_INT, 16'h8765, 16'h8765, 8'hbe}};

	pcseq_core i_pcseq_core (.mclk_i(mclk_i), .resetn_i(resetn_i), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd), .reg_rmw_i(rmw),
		.reg_rdata_o(rdata), .cmd_valid_i(cv),
		.cmd_i(pcseq_pkg::pcseq_cmd_s'({op, opc, top})), .wake_irq_i(wake),
		.fetch_o(fetch), .fetch_strobe_o(stb), .phase_o(ph));
	pcseq_partner i_pcseq_partner (.mclk_i(mclk_i), .resetn_i(resetn_i), .push_i(push),
		.push_data_i(pdata), .top_o(top));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Returns just after the phase-0 edge that refreshed the fetch output
	task automatic sync;
		do begin
			@(posedge mclk_i);
			#1;
		end while (ph !== 2'h1);
	endtask
	task automatic bus(input logic w, r, m, input logic [7:0] a, d);
		wr <= w;
		rd <= r;
		rmw <= m;
		addr <= a;
		wdata <= d;
		@(posedge mclk_i);
		#1;
		v = rdata;
	endtask
	task automatic idle;
		wr <= 1'b0;
		rd <= 1'b0;
		rmw <= 1'b0;
		cv <= 1'b0;
		push <= 1'b0;
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			fails++;
			summarize;
		end
	end

	initial begin
		{resetn_i, wr, rd, rmw, cv, wake, push, addr, wdata, opc, pdata} = '0;
		op = pcseq_pkg::PCSEQ_OP_NONE;
		repeat (3) @(posedge mclk_i);
		resetn_i <= 1'b1;
		sync;
		chk(fetch.addr, 16'h0000);
		bus(0, 1, 0, 8'h03, 8'h00);
		chk(16'(v), 16'h0000);
		bus(0, 1, 0, 8'h07, 8'h00);
		chk(16'(v), 16'h0000);
		idle;
		foreach (rows[i]) begin
			sync;
			push <= 1'b1;
			pdata <= rows[i].arg;
			bus(rows[i].op == pcseq_pkg::PCSEQ_OP_NONE, 0, 0, 8'h03, rows[i].arg[15:8]);
			push <= 1'b0;
			cv <= rows[i].op != pcseq_pkg::PCSEQ_OP_NONE;
			op <= rows[i].op;
			opc <= rows[i].arg;
			bus(wr, 0, 0, 8'h02, rows[i].arg[7:0]);
			idle;
			sync;
			chk(fetch.addr, rows[i].ea);
			bus(0, 1, 0, 8'h03, 8'h00);
			idle;
			chk(16'(v), 16'(rows[i].el));
		end
		sync;
		f = fetch.addr + 16'h0001;
		bus(0, 1, 0, 8'h02, 8'h00);
		chk(16'(v), 16'(f[7:0]));
		bus(0, 1, 0, 8'h03, 8'h00);
		chk(16'(v), 16'(f[15:8]));
		idle;
		sync;
		bus(1, 0, 0, 8'h03, 8'h5a);
		bus(0, 1, 1, 8'h02, 8'h00);
		bus(1, 0, 0, 8'h02, 8'h77);
		bus(0, 1, 0, 8'h03, 8'h00);
		idle;
		chk(16'(v), 16'h005a);
		chk(fetch.addr, 16'h5a77);
		sync;
		op <= pcseq_pkg::PCSEQ_OP_SKIP;
		cv <= 1'b1;
		@(posedge mclk_i);
		#1 idle;
		sync;
		chk(16'(fetch.forced_nop), 16'h0001);
		f = fetch.addr;
		sync;
		chk(16'(fetch.forced_nop), 16'h0000);
		chk(fetch.addr, f + 16'h0001);
		wake <= 1'b1;
		sync;
		chk(fetch.addr, `PCSEQ_VECTOR_RESET);
		bus(1, 0, 0, 8'h04, 8'h01);
		idle;
		wake <= 1'b0;
		sync;
		wake <= 1'b1;
		f = fetch.addr;
		sync;
		chk(fetch.addr, f + 16'h0001);
		// Mid-run reset
		@(posedge mclk_i);
		resetn_i <= 1'b0;
		wake <= 1'b0;
		repeat (3) @(posedge mclk_i);
		resetn_i <= 1'b1;
		sync;
		chk(fetch.addr, `PCSEQ_PC_RESET);
		chk(16'(stb), 16'h0000);
		bus(0, 1, 0, 8'h04, 8'h00);
		idle;
		chk(16'(v), 16'h0000);
		@(posedge mclk_i);
		#1 chk(16'(stb), 16'h0001);
		chk(16'(ph), 16'h0003);
		summarize;
	end
endmodule // program_counter_sequencer_tb
